// [hdl/ueb_map.vh]
`ifndef UEB_MAP_VH
`define UEB_MAP_VH
// endpoint bank geometry
`define UEB_BANK_DEPTH 64
`define UEB_PTR_W 6
`define UEB_CNT_W 7
// usb-side answers
`define UEB_HS_NONE 2'h0
`define UEB_HS_ACK 2'h1
`define UEB_HS_NAK 2'h2
`define UEB_HS_STALL 2'h3
// usb-side states
`define UEB_ST_IDLE 2'h0
`define UEB_ST_RX 2'h1
`define UEB_ST_TX 2'h2
`define UEB_ST_WAIT 2'h3
`endif

// [hdl/ueb_bank_ram.v]
`timescale 1ns/100ps
`include "ueb_map.vh"
// two banks of byte storage, one write port and one registered read port
module ueb_bank_ram (
	clk,
	wr_en,
	wr_addr,
	wr_data,
	rd_addr,
	rd_data
);
	input wire clk;
	input wire wr_en;
	input wire [`UEB_PTR_W:0] wr_addr;
	input wire [7:0] wr_data;
	input wire [`UEB_PTR_W:0] rd_addr;
	output reg [7:0] rd_data;
	reg [7:0] mem [0:2*`UEB_BANK_DEPTH-1];
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// [hdl/ueb_endpoint.v]
`timescale 1ns/100ps
`include "ueb_map.vh"
// Behaviour
// - ping-pong: two banks, processor and usb each own one; single bank: both use bank 0
// - tx_complete set on ack, holds interrupt
// - no ready bank: answer in with nak
// - single bank out: nak while busy, else ack
// - bank 0 stored sets flag, holds interrupt
// - byte count of current bank reported
// - single bank accepts after flag cleared
// - ping-pong: first bank 0, second bank 1
// - bank 0 cleared: third packet into it
// - bank 1 flag; interrupt while either set
// - force stall answers stall, sets stall flag
// - interrupt held while stall flag set
// - endpoint reset clears fifo pointers
// - dual bank cancel ready toggling, then reset
module ueb_endpoint (
	input wire clk,
	input wire rst_n,
	input wire ping_pong_en,
	input wire ep_reset,
	input wire force_stall_req,
	input wire tx_ready_set,
	input wire tx_ready_clr,
	input wire tx_complete_clr,
	input wire rx_bank0_clr,
	input wire rx_bank1_clr,
	input wire stall_sent_clr,
	input wire fifo_wr,
	input wire [7:0] fifo_wdata,
	input wire fifo_rd,
	output reg [7:0] fifo_rdata,
	output wire tx_packet_ready,
	output reg tx_complete,
	output reg rx_bank0_full,
	output reg rx_bank1_full,
	output reg stall_sent_flag,
	output reg [`UEB_CNT_W-1:0] rx_byte_count,
	output wire ep_irq,
	input wire usb_in_req,
	input wire usb_out_start,
	input wire usb_out_valid,
	input wire [7:0] usb_out_data,
	input wire usb_out_end,
	input wire usb_host_ack,
	input wire usb_tx_pull,
	output reg [7:0] usb_tx_data,
	output reg usb_tx_valid,
	output reg usb_tx_last,
	output reg [1:0] usb_hs,
	output reg usb_hs_valid
);
	reg [1:0] state_r;
	reg usb_bank_r;
	reg cpu_bank_r;
	reg [1:0] txrdy_r;
	reg [`UEB_CNT_W-1:0] bank_len_r [0:1];
	reg [`UEB_CNT_W-1:0] cpu_ptr_r;
	reg [`UEB_CNT_W-1:0] usb_ptr_r;
	reg rd_pend_r;
	wire [7:0] ram_q;
	wire [`UEB_PTR_W:0] ram_wa;
	wire [`UEB_PTR_W:0] ram_ra;
	wire ram_we;
	wire out_bank;
	wire out_free;
	wire rx_in_cur;
	localparam [`UEB_CNT_W-1:0] cnt_one = {{(`UEB_CNT_W-1){1'b0}}, 1'b1};

	function bank_full;
		input b;
		input f0;
		input f1;
		begin
			bank_full = b ? f1 : f0;
		end
	endfunction

	assign tx_packet_ready = txrdy_r[cpu_bank_r] | txrdy_r[~cpu_bank_r];
	assign ep_irq = tx_complete | rx_bank0_full | rx_bank1_full | stall_sent_flag;
	// single bank always uses bank 0 and waits for the flag to clear
	assign out_bank = ping_pong_en ? usb_bank_r : 1'b0;
	assign out_free = ~bank_full(out_bank, rx_bank0_full, rx_bank1_full) &
		(ping_pong_en | ~rx_bank0_full);
	assign rx_in_cur = bank_full(cpu_bank_r, rx_bank0_full, rx_bank1_full);
	assign ram_we = (state_r == `UEB_ST_RX) ? (usb_out_valid & (usb_ptr_r < `UEB_BANK_DEPTH)) :
		(fifo_wr & ~txrdy_r[cpu_bank_r] & (cpu_ptr_r < `UEB_BANK_DEPTH));
	assign ram_wa = (state_r == `UEB_ST_RX) ? {out_bank, usb_ptr_r[`UEB_PTR_W-1:0]} :
		{cpu_bank_r, cpu_ptr_r[`UEB_PTR_W-1:0]};
	assign ram_ra = (state_r == `UEB_ST_TX) ? {usb_bank_r, usb_ptr_r[`UEB_PTR_W-1:0]} :
		{cpu_bank_r, cpu_ptr_r[`UEB_PTR_W-1:0]};

	ueb_bank_ram u_ram (
		.clk(clk),
		.wr_en(ram_we),
		.wr_addr(ram_wa),
		.wr_data((state_r == `UEB_ST_RX) ? usb_out_data : fifo_wdata),
		.rd_addr(ram_ra),
		.rd_data(ram_q)
	);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= `UEB_ST_IDLE;
			usb_bank_r <= 1'b0;
			cpu_bank_r <= 1'b0;
			txrdy_r <= 2'h0;
			bank_len_r[0] <= {`UEB_CNT_W{1'b0}};
			bank_len_r[1] <= {`UEB_CNT_W{1'b0}};
			cpu_ptr_r <= {`UEB_CNT_W{1'b0}};
			usb_ptr_r <= {`UEB_CNT_W{1'b0}};
			rd_pend_r <= 1'b0;
			fifo_rdata <= 8'h00;
			tx_complete <= 1'b0;
			rx_bank0_full <= 1'b0;
			rx_bank1_full <= 1'b0;
			stall_sent_flag <= 1'b0;
			rx_byte_count <= {`UEB_CNT_W{1'b0}};
			usb_tx_data <= 8'h00;
			usb_tx_valid <= 1'b0;
			usb_tx_last <= 1'b0;
			usb_hs <= `UEB_HS_NONE;
			usb_hs_valid <= 1'b0;
		end else begin
			usb_hs_valid <= 1'b0;
			usb_tx_valid <= 1'b0;
			usb_tx_last <= 1'b0;
			rd_pend_r <= fifo_rd & rx_in_cur;
			if (rd_pend_r) begin
				fifo_rdata <= ram_q;
			end
			// clears first so that a same-cycle hardware set wins
			if (tx_complete_clr) begin
				tx_complete <= 1'b0;
			end
			if (stall_sent_clr) begin
				stall_sent_flag <= 1'b0;
			end
			if (rx_bank0_clr && rx_bank0_full) begin
				rx_bank0_full <= 1'b0;
				if (ping_pong_en) begin
					cpu_bank_r <= ~cpu_bank_r;
				end
				cpu_ptr_r <= {`UEB_CNT_W{1'b0}};
			end
			if (rx_bank1_clr && rx_bank1_full) begin
				rx_bank1_full <= 1'b0;
				cpu_bank_r <= ~cpu_bank_r;
				cpu_ptr_r <= {`UEB_CNT_W{1'b0}};
			end
			if (fifo_wr && state_r != `UEB_ST_RX && !txrdy_r[cpu_bank_r] && cpu_ptr_r < `UEB_BANK_DEPTH) begin
				cpu_ptr_r <= cpu_ptr_r + cnt_one;
			end
			if (fifo_rd && rx_in_cur && cpu_ptr_r < bank_len_r[cpu_bank_r]) begin
				cpu_ptr_r <= cpu_ptr_r + cnt_one;
			end
			rx_byte_count <= rx_in_cur ? bank_len_r[cpu_bank_r] : {`UEB_CNT_W{1'b0}};
			if (tx_ready_set && !txrdy_r[cpu_bank_r]) begin
				txrdy_r[cpu_bank_r] <= 1'b1;
				bank_len_r[cpu_bank_r] <= cpu_ptr_r;
				cpu_ptr_r <= {`UEB_CNT_W{1'b0}};
				if (ping_pong_en) begin
					cpu_bank_r <= ~cpu_bank_r;
				end
			end
			if (tx_ready_clr) begin
				txrdy_r <= 2'h0;
			end
			case (state_r)
				`UEB_ST_IDLE: begin
					if (force_stall_req && (usb_in_req || usb_out_start)) begin
						usb_hs <= `UEB_HS_STALL;
						usb_hs_valid <= 1'b1;
						stall_sent_flag <= 1'b1;
					end else if (usb_in_req) begin
						if (txrdy_r[usb_bank_r]) begin
							state_r <= `UEB_ST_TX;
							usb_ptr_r <= {`UEB_CNT_W{1'b0}};
						end else begin
							usb_hs <= `UEB_HS_NAK;
							usb_hs_valid <= 1'b1;
						end
					end else if (usb_out_start) begin
						if (out_free) begin
							state_r <= `UEB_ST_RX;
							usb_ptr_r <= {`UEB_CNT_W{1'b0}};
						end else begin
							usb_hs <= `UEB_HS_NAK;
							usb_hs_valid <= 1'b1;
						end
					end
				end
				`UEB_ST_RX: begin
					if (ram_we) begin
						usb_ptr_r <= usb_ptr_r + cnt_one;
					end
					if (usb_out_end) begin
						bank_len_r[out_bank] <= usb_ptr_r + {{(`UEB_CNT_W-1){1'b0}}, ram_we};
						if (out_bank) begin
							rx_bank1_full <= 1'b1;
						end else begin
							rx_bank0_full <= 1'b1;
						end
						if (ping_pong_en) begin
							usb_bank_r <= ~usb_bank_r;
						end
						usb_hs <= `UEB_HS_ACK;
						usb_hs_valid <= 1'b1;
						state_r <= `UEB_ST_IDLE;
					end
				end
				`UEB_ST_TX: begin
					if (usb_tx_pull) begin
						if (usb_ptr_r >= bank_len_r[usb_bank_r]) begin
							usb_tx_last <= 1'b1;
							usb_tx_valid <= 1'b1;
							state_r <= `UEB_ST_WAIT;
						end else begin
							usb_tx_data <= ram_q;
							usb_tx_valid <= 1'b1;
							usb_ptr_r <= usb_ptr_r + cnt_one;
						end
					end
				end
				`UEB_ST_WAIT: begin
					if (usb_host_ack) begin
						txrdy_r[usb_bank_r] <= 1'b0;
						tx_complete <= 1'b1;
						if (ping_pong_en) begin
							usb_bank_r <= ~usb_bank_r;
						end
						state_r <= `UEB_ST_IDLE;
					end else if (usb_in_req || usb_out_start) begin
						state_r <= `UEB_ST_IDLE;
					end
				end
				default: begin
					state_r <= `UEB_ST_IDLE;
				end
			endcase
			if (ep_reset) begin
				state_r <= `UEB_ST_IDLE;
				usb_bank_r <= 1'b0;
				cpu_bank_r <= 1'b0;
				cpu_ptr_r <= {`UEB_CNT_W{1'b0}};
				usb_ptr_r <= {`UEB_CNT_W{1'b0}};
				txrdy_r <= 2'h0;
				rx_bank0_full <= 1'b0;
				rx_bank1_full <= 1'b0;
			end
		end
	end
endmodule

// [verif/ueb_endpoint_checker.sv]
`timescale 1ns/100ps
`include "ueb_map.vh"
module ueb_endpoint_checker (
	input wire clk,
	input wire rst_n,
	input wire ping_pong_en,
	input wire ep_reset,
	input wire force_stall_req,
	input wire tx_ready_clr,
	input wire usb_out_end,
	input wire usb_host_ack,
	input wire tx_packet_ready,
	input wire tx_complete,
	input wire rx_bank0_full,
	input wire rx_bank1_full,
	input wire stall_sent_flag,
	input wire [`UEB_CNT_W-1:0] rx_byte_count,
	input wire ep_irq,
	input wire [1:0] usb_hs,
	input wire usb_hs_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire any_rx = rx_bank0_full | rx_bank1_full;
	property p_irq; ep_irq == (tx_complete | any_rx | stall_sent_flag); endproperty
	a_irq: assert property (p_irq) else $error("irq not flag or");
	property p_txc; $rose(tx_complete) |-> $past(usb_host_ack); endproperty
	a_txc: assert property (p_txc) else $error("tx complete w/o ack");
	property p_rx0; $rose(rx_bank0_full) |-> $past(usb_out_end); endproperty
	a_rx0: assert property (p_rx0) else $error("bank0 full w/o end");
	property p_rx1; $rose(rx_bank1_full) |-> $past(usb_out_end & ping_pong_en); endproperty
	a_rx1: assert property (p_rx1) else $error("bank1 full bad");
	property p_ack1; usb_hs_valid && usb_hs == `UEB_HS_ACK && !ping_pong_en |-> !$past(rx_bank0_full); endproperty
	a_ack1: assert property (p_ack1) else $error("ack while full");
	property p_stall; usb_hs_valid && usb_hs == `UEB_HS_STALL |-> $past(force_stall_req); endproperty
	a_stall: assert property (p_stall) else $error("stall unrequested");
	property p_rst; ep_reset |=> !tx_packet_ready && !any_rx; endproperty
	a_rst: assert property (p_rst) else $error("reset left state");
	property p_clr; tx_ready_clr && !ep_reset |=> !tx_packet_ready; endproperty
	a_clr: assert property (p_clr) else $error("ready not cleared");
	property p_cnt; !any_rx ##1 !any_rx |-> rx_byte_count == 0; endproperty
	a_cnt: assert property (p_cnt) else $error("count without data");
endmodule
bind ueb_endpoint ueb_endpoint_checker chk_u (.clk(clk), .rst_n(rst_n),
	.ping_pong_en(ping_pong_en), .ep_reset(ep_reset), .force_stall_req(force_stall_req),
	.tx_ready_clr(tx_ready_clr), .usb_out_end(usb_out_end), .usb_host_ack(usb_host_ack),
	.tx_packet_ready(tx_packet_ready), .tx_complete(tx_complete), .rx_bank0_full(rx_bank0_full),
	.rx_bank1_full(rx_bank1_full), .stall_sent_flag(stall_sent_flag), .rx_byte_count(rx_byte_count),
	.ep_irq(ep_irq), .usb_hs(usb_hs), .usb_hs_valid(usb_hs_valid));

// [verif/ueb_host_model.sv]
`timescale 1ns/100ps
module ueb_host_model (
	input wire clk,
	output logic usb_in_req = 0,
	output logic usb_out_start = 0,
	output logic usb_out_valid = 0,
	output logic [7:0] usb_out_data = 0,
	output logic usb_out_end = 0,
	output logic usb_host_ack = 0,
	output logic usb_tx_pull = 0,
	input wire [7:0] usb_tx_data,
	input wire usb_tx_valid,
	input wire usb_tx_last,
	input wire [1:0] usb_hs,
	input wire usb_hs_valid
);
	logic [1:0] hs_r = 0;
	logic [7:0] got[$];
	always @(posedge clk) begin
		if (usb_hs_valid)
			hs_r <= usb_hs;
		if (usb_tx_valid && !usb_tx_last)
			got.push_back(usb_tx_data);
	end
	task out_pkt(input int n, input logic [7:0] b);
		hs_r <= 2'h0;
		@(posedge clk) usb_out_start <= 1'b1;
		@(posedge clk) usb_out_start <= 1'b0;
		for (int i = 0; i < n; i++) begin
			usb_out_valid <= 1'b1;
			usb_out_data <= b + 8'(i);
			usb_out_end <= (i == n - 1);
			@(posedge clk);
		end
		{usb_out_valid, usb_out_end} <= 2'h0;
		usb_out_data <= ~usb_out_data;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// only a data packet is acknowledged, never a nak or stall
	task in_pkt(input int n);
		hs_r <= 2'h0;
		got.delete();
		@(posedge clk) usb_in_req <= 1'b1;
		@(posedge clk) usb_in_req <= 1'b0;
		repeat (n + 1) begin
			@(posedge clk) usb_tx_pull <= 1'b1;
			@(posedge clk) usb_tx_pull <= 1'b0;
		end
		@(posedge clk) usb_host_ack <= (hs_r == 2'h0);
		@(posedge clk) usb_host_ack <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
endmodule

// [verif/usb_endpoint_bank_handshake_test.sv]
`timescale 1ns/100ps
`include "ueb_map.vh"
module usb_endpoint_bank_handshake_test;
	logic clk = 0, rst_n = 0, pp = 0, stl = 0, wr = 0, rd = 0;
	logic [6:0] p = 0;
	logic [7:0] wd = 0;
	wire [7:0] rdat, txd, od;
	wire [`UEB_CNT_W-1:0] cnt;
	wire [1:0] hs;
	wire txr, txc, rx0, rx1, ssf, irq, inq, ost, ov, oe, ack, pull, tv, tl, hv;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	always #4 clk = ~clk;
	ueb_endpoint dut_u (.clk(clk), .rst_n(rst_n), .ping_pong_en(pp), .ep_reset(p[0]),
		.force_stall_req(stl), .tx_ready_set(p[1]), .tx_ready_clr(p[2]), .tx_complete_clr(p[3]),
		.rx_bank0_clr(p[4]), .rx_bank1_clr(p[5]), .stall_sent_clr(p[6]), .fifo_wr(wr),
		.fifo_wdata(wd), .fifo_rd(rd), .fifo_rdata(rdat), .tx_packet_ready(txr),
		.tx_complete(txc), .rx_bank0_full(rx0), .rx_bank1_full(rx1), .stall_sent_flag(ssf),
		.rx_byte_count(cnt), .ep_irq(irq), .usb_in_req(inq), .usb_out_start(ost),
		.usb_out_valid(ov), .usb_out_data(od), .usb_out_end(oe), .usb_host_ack(ack),
		.usb_tx_pull(pull), .usb_tx_data(txd), .usb_tx_valid(tv), .usb_tx_last(tl),
		.usb_hs(hs), .usb_hs_valid(hv));
	ueb_host_model h (.clk(clk), .usb_in_req(inq), .usb_out_start(ost), .usb_out_valid(ov),
		.usb_out_data(od), .usb_out_end(oe), .usb_host_ack(ack), .usb_tx_pull(pull),
		.usb_tx_data(txd), .usb_tx_valid(tv), .usb_tx_last(tl), .usb_hs(hs), .usb_hs_valid(hv));
	task end_sim;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task pulse(input int k);
		@(posedge clk) p[k] <= 1'b1;
		@(posedge clk) p <= 7'h00;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task wr_b(input logic [7:0] d);
		@(posedge clk) {wr, wd} <= {1'b1, d};
		@(posedge clk) wr <= 1'b0;
	endtask
	task rd_b(input logic [7:0] e);
		@(posedge clk) rd <= 1'b1;
		@(posedge clk) rd <= 1'b0;
		@(posedge clk) #1 chk("rdata", e, rdat);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		h.out_pkt(3, 8'h10);
		chk("hs", 8'h01, 8'(h.hs_r));
		chk("rxf", 8'h05, 8'({irq, rx1, rx0}));
		chk("cnt", 8'h03, 8'(cnt));
		h.out_pkt(2, 8'h50);
		chk("hs", 8'h02, 8'(h.hs_r));
		for (int i = 0; i < 3; i++) rd_b(8'h10 + 8'(i));
		pulse(4);
		chk("irq", 8'h00, 8'(irq));
		@(posedge clk) pp <= 1'b1;
		h.out_pkt(2, 8'h20);
		h.out_pkt(4, 8'h30);
		chk("rxf", 8'h07, 8'({irq, rx1, rx0}));
		chk("cnt", 8'h02, 8'(cnt));
		rd_b(8'h20);
		pulse(4);
		chk("cnt", 8'h04, 8'(cnt));
		h.out_pkt(1, 8'h40);
		chk("hs", 8'h01, 8'(h.hs_r));
		pulse(5);
		pulse(4);
		pulse(0);
		wr_b(8'ha1);
		wr_b(8'ha2);
		pulse(1);
		wr_b(8'hb1);
		h.in_pkt(2);
		chk("in0", 8'ha1, h.got[0]);
		chk("in1", 8'ha2, h.got[1]);
		chk("txc", 8'h03, 8'({irq, txc}));
		pulse(1);
		pulse(3);
		h.in_pkt(1);
		chk("in2", 8'hb1, h.got[0]);
		pulse(3);
		h.in_pkt(0);
		chk("hs", 8'h02, 8'(h.hs_r));
		@(posedge clk) stl <= 1'b1;
		h.in_pkt(0);
		chk("hs", 8'h03, 8'(h.hs_r));
		chk("ssf", 8'h03, 8'({irq, ssf}));
		@(posedge clk) stl <= 1'b0;
		pulse(6);
		chk("irq", 8'h00, 8'(irq));
		@(posedge clk) pp <= 1'b0;
		wr_b(8'hc1);
		pulse(1);
		chk("txr", 8'h01, 8'(txr));
		pulse(2);
		pulse(0);
		chk("txr", 8'h00, 8'(txr));
		wr_b(8'hd1);
		pulse(1);
		h.in_pkt(1);
		chk("in3", 8'hd1, h.got[0]);
		pulse(3);
		@(posedge clk) pp <= 1'b1;
		wr_b(8'he1);
		pulse(1);
		pulse(2);
		chk("txr", 8'h00, 8'(txr));
		pulse(1);
		chk("txr", 8'h01, 8'(txr));
		pulse(2);
		pulse(0);
		chk("txr", 8'h00, 8'(txr));
		h.in_pkt(0);
		chk("hs", 8'h02, 8'(h.hs_r));
		end_sim;
	end
endmodule
